// ### src/sdies_status.sv
// Error status, error mask and data format reporting of the SDI receiver
`include "sdies_regs.svh"
`default_nettype none
module sdies_status
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Host register port
    input wire logic [11:0] i_host_addr,
    input wire logic i_host_rd,
    input wire logic i_host_wr,
    input wire logic [15:0] i_host_wdata,
    output logic [15:0] o_host_rdata,
    output logic o_host_rvalid,
    // Detector events and modes
    input wire sdies_pkg::sdies_events_t i_events,
    input wire sdies_pkg::sdies_mode_t i_mode,
    input wire sdies_pkg::sdies_format_t i_format,
    input wire logic i_field_start,
    input wire logic i_std_change,
    // Pins from outside the clock domain
    input wire logic i_locked,
    input wire logic i_processing_bypass_n,
    // Status outputs
    output sdies_pkg::sdies_format_t o_format,
    output logic o_data_error_n
);

    logic [2:0] lock_sync_ff, nxt_lock_sync;
    logic [2:0] byp_sync_ff, nxt_byp_sync;
    logic lock_ff, nxt_lock;
    logic byp_ff, nxt_byp;
    logic [10:0] flags_ff, nxt_flags;
    logic [10:0] mask_ff, nxt_mask;
    sdies_pkg::sdies_format_t fmt_ff, nxt_fmt;
    logic [15:0] rdata_ff, nxt_rdata;
    logic rvalid_ff, nxt_rvalid;
    logic err_n_ff, nxt_err_n;
    logic [10:0] set_v;
    logic [10:0] clr_v;
    logic rd_flags;
    logic smpte_active;
    logic hd;

    // Pin synchronisers and debounced levels
    always_comb
    begin
        nxt_lock_sync = {lock_sync_ff[1:0], i_locked};
        nxt_byp_sync = {byp_sync_ff[1:0], i_processing_bypass_n};
        nxt_lock = (lock_sync_ff[2] == lock_sync_ff[1]) ? lock_sync_ff[1] : lock_ff;
        nxt_byp = (byp_sync_ff[2] == byp_sync_ff[1]) ? byp_sync_ff[1] : byp_ff;
    end

    // Error event qualification and flag update
    always_comb
    begin
        hd = ~i_mode.rate_select;
        smpte_active = i_mode.smpte_mode & ~i_mode.data_through;
        rd_flags = i_host_rd && (i_host_addr == `SDIES_ADDR_ERROR_FLAGS);
        set_v = '0;
        set_v[`SDIES_BIT_STD_MISMATCH] = i_events.standard_mismatch;
        set_v[`SDIES_BIT_FULL_FIELD_CRC] = i_events.full_field_crc & ~hd;
        set_v[`SDIES_BIT_ACTIVE_PIC_CRC] = i_events.active_picture_crc & ~hd;
        set_v[`SDIES_BIT_CHROMA_CKSUM] = i_events.chroma_checksum;
        set_v[`SDIES_BIT_LUMA_CKSUM] = i_events.luma_checksum;
        set_v[`SDIES_BIT_CHROMA_LCRC] = i_events.chroma_line_crc & hd;
        set_v[`SDIES_BIT_LUMA_LCRC] = i_events.luma_line_crc & hd;
        set_v[`SDIES_BIT_LINE_NUM] = i_events.line_number & hd;
        set_v[`SDIES_BIT_SAV] = i_events.start_active_video & i_mode.flywheel_enable;
        set_v[`SDIES_BIT_EAV] = i_events.end_active_video & i_mode.flywheel_enable;
        if (!smpte_active)
        begin
            set_v = '0;
        end
        set_v[`SDIES_BIT_LOCK] = ~lock_ff;
        set_v = set_v & ~mask_ff;
        clr_v = '0;
        // field start or read clears all
        if (i_field_start || rd_flags)
        begin
            clr_v = '1;
        end
        if (i_std_change || !lock_ff || (i_mode.slave_mode && !byp_ff))
        begin
            clr_v = clr_v | ~(11'h001 << `SDIES_BIT_LOCK);
        end
        nxt_flags = (flags_ff & ~clr_v) | set_v;
        nxt_err_n = ~|(nxt_flags & ~nxt_mask);
    end

    // Mask register and host read path
    always_comb
    begin
        nxt_mask = mask_ff;
        if (i_host_wr && (i_host_addr == `SDIES_ADDR_ERROR_MASK))
        begin
            nxt_mask = i_host_wdata[10:0];
        end
        nxt_rvalid = i_host_rd;
        nxt_rdata = rdata_ff;
        if (i_host_rd)
        begin
            if (i_host_addr == `SDIES_ADDR_ERROR_FLAGS)
            begin
                nxt_rdata = {5'h00, flags_ff};
            end
            else if (i_host_addr == `SDIES_ADDR_ERROR_MASK)
            begin
                nxt_rdata = {5'h00, mask_ff};
            end
            else if (i_host_addr == `SDIES_ADDR_VIDEO_STD)
            begin
                nxt_rdata = {8'h00, fmt_ff};
            end
            else
            begin
                nxt_rdata = 16'h0000;
            end
        end
    end

    // Data format fields
    always_comb
    begin
        nxt_fmt = i_format;
        if (i_mode.rate_select || !i_mode.smpte_mode)
        begin
            nxt_fmt.chroma_format_code = `SDIES_FMT_UNKNOWN;
        end
        // unknown on lock loss or data-through
        if (!lock_ff || i_mode.data_through)
        begin
            nxt_fmt.luma_format_code = `SDIES_FMT_UNKNOWN;
            nxt_fmt.chroma_format_code = `SDIES_FMT_UNKNOWN;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            lock_sync_ff <= 3'h0;
            byp_sync_ff <= 3'h7;
            lock_ff <= 1'b0;
            byp_ff <= 1'b1;
            flags_ff <= `SDIES_FLAGS_RESET;
            mask_ff <= `SDIES_MASK_RESET;
            fmt_ff <= {`SDIES_FMT_UNKNOWN, `SDIES_FMT_UNKNOWN};
            rdata_ff <= 16'h0000;
            rvalid_ff <= 1'b0;
            err_n_ff <= 1'b1;
        end
        else
        begin
            lock_sync_ff <= nxt_lock_sync;
            byp_sync_ff <= nxt_byp_sync;
            lock_ff <= nxt_lock;
            byp_ff <= nxt_byp;
            flags_ff <= nxt_flags;
            mask_ff <= nxt_mask;
            fmt_ff <= nxt_fmt;
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
            err_n_ff <= nxt_err_n;
        end
    end

    assign o_host_rdata = rdata_ff;
    assign o_host_rvalid = rvalid_ff;
    assign o_format = fmt_ff;
    assign o_data_error_n = err_n_ff;

    a_lock_flag_set: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (!lock_ff && !mask_ff[`SDIES_BIT_LOCK]) |=> flags_ff[`SDIES_BIT_LOCK])
        else $error("lock flag not set");
    a_pin_or_flags: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        ##1 (err_n_ff == ~|(flags_ff & ~mask_ff)))
        else $error("error pin mismatch");
    a_read_clears: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (rd_flags && set_v == 11'h000) |=> (flags_ff == 11'h000))
        else $error("read did not clear");
    a_set_wins: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (i_field_start || rd_flags) |=> ((flags_ff & $past(set_v)) == $past(set_v)))
        else $error("event lost on clear");
    // lock loss keeps only lock bit
    a_lockloss_clear: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (!lock_ff) |=> ((flags_ff & ~(11'h001 << `SDIES_BIT_LOCK)) == 11'h000))
        else $error("lock loss clear failed");
    a_nonsmpte_quiet: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (!smpte_active && $past(!smpte_active) && !i_std_change && $past(rd_flags))
        |-> ((flags_ff & ~(11'h001 << `SDIES_BIT_LOCK)) == 11'h000))
        else $error("non-SMPTE flag set");
    // masked line number bit stays clear after a flags read
    a_mask_blocks: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (mask_ff[`SDIES_BIT_LINE_NUM] && $past(rd_flags)) |-> !flags_ff[`SDIES_BIT_LINE_NUM])
        else $error("masked flag set");
    a_fmt_unknown: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (!lock_ff) |=> (fmt_ff == {`SDIES_FMT_UNKNOWN, `SDIES_FMT_UNKNOWN}))
        else $error("format not unknown");
    a_mask_write: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (i_host_wr && i_host_addr == `SDIES_ADDR_ERROR_MASK)
        |=> (mask_ff == $past(i_host_wdata[10:0])))
        else $error("mask write lost");
    a_event_sets: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (smpte_active && i_events.luma_checksum && !mask_ff[`SDIES_BIT_LUMA_CKSUM])
        |=> flags_ff[`SDIES_BIT_LUMA_CKSUM])
        else $error("checksum flag not set");
    a_std_mismatch: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (smpte_active && i_events.standard_mismatch && !mask_ff[`SDIES_BIT_STD_MISMATCH])
        |=> flags_ff[`SDIES_BIT_STD_MISMATCH])
        else $error("standard flag not set");
    a_field_clears: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (i_field_start && set_v == 11'h000)
        |=> (flags_ff == 11'h000))
        else $error("field start did not clear");
    // standard change keeps only lock bit
    a_stdchg_clear: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (i_std_change && (set_v & ~(11'h001 << `SDIES_BIT_LOCK)) == 11'h000)
        |=> ((flags_ff & ~(11'h001 << `SDIES_BIT_LOCK)) == 11'h000))
        else $error("standard change clear failed");
    a_mask_hold: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (!(i_host_wr && (i_host_addr == `SDIES_ADDR_ERROR_MASK)))
        |=> $stable(mask_ff))
        else $error("mask changed without write");
    a_fmt_hd_pass: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (lock_ff && !i_mode.data_through && i_mode.smpte_mode && !i_mode.rate_select)
        |=> (fmt_ff == $past(i_format)))
        else $error("HD format not passed");
    a_fmt_sd_chroma: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (lock_ff && !i_mode.data_through && (i_mode.rate_select || !i_mode.smpte_mode))
        |=> (fmt_ff == {`SDIES_FMT_UNKNOWN, $past(i_format.luma_format_code)}))
        else $error("SD format fields wrong");
    a_fmt_through: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (i_mode.data_through)
        |=> (fmt_ff == {`SDIES_FMT_UNKNOWN, `SDIES_FMT_UNKNOWN}))
        else $error("data-through format not unknown");
    a_edh_sd_only: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (rd_flags && hd)
        |=> (!flags_ff[`SDIES_BIT_FULL_FIELD_CRC] && !flags_ff[`SDIES_BIT_ACTIVE_PIC_CRC]))
        else $error("EDH flag set in HD");
    a_hd_only_bits: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (rd_flags && !hd)
        |=> (flags_ff[`SDIES_BIT_CHROMA_LCRC:`SDIES_BIT_LINE_NUM] == 3'h0))
        else $error("HD-only flag set in SD");
    a_trs_flywheel: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (rd_flags && !i_mode.flywheel_enable)
        |=> (flags_ff[`SDIES_BIT_SAV:`SDIES_BIT_EAV] == 2'h0))
        else $error("TRS flag set without flywheel");
    // Read valid follows read strobe
    a_read_valid: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        ##1 (rvalid_ff == $past(i_host_rd)))
        else $error("read valid mismatch");

endmodule
`default_nettype wire

// ### src/sdies_regs.svh
// Register offsets, field positions, reset values and codes for the SDI error status block
`ifndef SDIES_REGS_SVH
`define SDIES_REGS_SVH

`define SDIES_ADDR_ERROR_FLAGS 12'h001
`define SDIES_ADDR_VIDEO_STD 12'h00d
`define SDIES_ADDR_ERROR_MASK 12'h01a

`define SDIES_BIT_STD_MISMATCH 10
`define SDIES_BIT_FULL_FIELD_CRC 9
`define SDIES_BIT_ACTIVE_PIC_CRC 8
`define SDIES_BIT_LOCK 7
`define SDIES_BIT_CHROMA_CKSUM 6
`define SDIES_BIT_LUMA_CKSUM 5
`define SDIES_BIT_CHROMA_LCRC 4
`define SDIES_BIT_LUMA_LCRC 3
`define SDIES_BIT_LINE_NUM 2
`define SDIES_BIT_SAV 1
`define SDIES_BIT_EAV 0

`define SDIES_FLAGS_RESET 11'h000
`define SDIES_MASK_RESET 11'h000
`define SDIES_FMT_UNKNOWN 4'hf
`define SDIES_FMT_SDI 4'h6
`define SDIES_FMT_DVB_ASI 4'h7

`endif

// ### src/sdies_pkg.sv
// Types shared by the SDI error status block
`default_nettype none
package sdies_pkg;
    typedef struct packed {
        logic standard_mismatch;
        logic full_field_crc;
        logic active_picture_crc;
        logic chroma_checksum;
        logic luma_checksum;
        logic chroma_line_crc;
        logic luma_line_crc;
        logic line_number;
        logic start_active_video;
        logic end_active_video;
    } sdies_events_t;

    typedef struct packed {
        logic rate_select;
        logic smpte_mode;
        logic data_through;
        logic slave_mode;
        logic flywheel_enable;
    } sdies_mode_t;

    typedef struct packed {
        logic [3:0] chroma_format_code;
        logic [3:0] luma_format_code;
    } sdies_format_t;
endpackage
`default_nettype wire

// ### bench/sdies_host.sv
// Host controller model issuing register reads and writes
`default_nettype none
module sdies_host
(
    // Clock
    input wire logic i_sys_clk,
    // Register port
    output logic [11:0] o_addr,
    output logic o_rd,
    output logic o_wr,
    output logic [15:0] o_wdata,
    input wire logic [15:0] i_rdata,
    input wire logic i_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        o_addr = 12'hfff;
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_wdata = 16'h0000;
    end
    task automatic rd(input logic [11:0] a, output logic [15:0] d);
        @(posedge i_sys_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_sys_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1;
        d = i_rvalid ? i_rdata : 16'hdead;
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge i_sys_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_sys_clk);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask
endmodule
`default_nettype wire

// ### bench/sdi_error_status_and_format_tb.sv
// Self-checking bench for the SDI error status block
`include "sdies_regs.svh"
`default_nettype none
module sdi_error_status_and_format_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_sys_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [11:0] addr;
    logic rd, wr, rvalid, err_n;
    logic [15:0] wdata, rdata, d;
    logic fs = 1'b0, sc = 1'b0, lk = 1'b1, byp_n = 1'b1;
    sdies_pkg::sdies_events_t ev = '0;
    sdies_pkg::sdies_mode_t md = 5'h09;
    sdies_pkg::sdies_format_t fmt = 8'h68, fo;
    int fails = 0, checked = 0;
    always #2 i_sys_clk = ~i_sys_clk;
    sdies_status dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_host_addr(addr),
        .i_host_rd(rd), .i_host_wr(wr), .i_host_wdata(wdata), .o_host_rdata(rdata),
        .o_host_rvalid(rvalid), .i_events(ev), .i_mode(md), .i_format(fmt),
        .i_field_start(fs), .i_std_change(sc), .i_locked(lk),
        .i_processing_bypass_n(byp_n), .o_format(fo), .o_data_error_n(err_n));
    sdies_host host (.i_sys_clk(i_sys_clk), .o_addr(addr), .o_rd(rd), .o_wr(wr),
        .o_wdata(wdata), .i_rdata(rdata), .i_rvalid(rvalid));
    task automatic results();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        checked++;
        if (s !== e)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask
    task automatic flags(input logic [15:0] e);
        host.rd(`SDIES_ADDR_ERROR_FLAGS, d);
        chk("flags", e, d);
    endtask
    task automatic pulse(input int i);
        @(posedge i_sys_clk);
        ev <= sdies_pkg::sdies_events_t'(10'h001 << i);
        @(posedge i_sys_clk);
        ev <= '0;
        #1;
    endtask
    task automatic t_reset();
        tick(8);
        flags(16'h0080);
        flags(16'h0000);
        chk("pin", 16'h0001, {15'h0, err_n});
        host.rd(`SDIES_ADDR_ERROR_MASK, d);
        chk("mask", 16'h0000, d);
    endtask
    task automatic t_format();
        logic [4:0] m[4] = '{5'h09, 5'h19, 5'h1d, 5'h01};
        logic [7:0] f[4] = '{8'h68, 8'h86, 8'h86, 8'h67};
        logic [15:0] e[4] = '{16'h0068, 16'h00f6, 16'h00ff, 16'h00f7};
        for (int k = 0; k < 4; k++)
        begin
            @(posedge i_sys_clk);
            md <= m[k];
            fmt <= f[k];
            tick(3);
            host.rd(`SDIES_ADDR_VIDEO_STD, d);
            chk("format", e[k], d);
        end
    endtask
    task automatic t_events();
        int b;
        logic ok;
        for (int i = 0; i < 10; i++)
            for (int sd = 0; sd < 2; sd++)
            begin
                @(posedge i_sys_clk);
                md <= sd ? 5'h19 : 5'h09;
                tick(2);
                pulse(i);
                b = i < 7 ? i : i + 1;
                ok = (i == 7 || i == 8) ? sd == 1 : (i >= 2 && i <= 4) ? sd == 0 : 1'b1;
                chk("pin", {15'h0, !ok}, {15'h0, err_n});
                flags(ok ? 16'h0001 << b : 16'h0000);
            end
    endtask
    task automatic t_qualify();
        logic [4:0] m[3] = '{5'h08, 5'h0d, 5'h01};
        int i[3] = '{0, 5, 5};
        for (int k = 0; k < 3; k++)
        begin
            @(posedge i_sys_clk);
            md <= m[k];
            tick(2);
            pulse(i[k]);
            flags(16'h0000);
        end
        @(posedge i_sys_clk);
        md <= 5'h09;
    endtask
    task automatic t_mask();
        host.wr(`SDIES_ADDR_ERROR_MASK, 16'hffff);
        host.rd(`SDIES_ADDR_ERROR_MASK, d);
        chk("mask", 16'h07ff, d);
        pulse(2);
        chk("pin", 16'h0001, {15'h0, err_n});
        flags(16'h0000);
        host.wr(`SDIES_ADDR_ERROR_MASK, 16'h0020);
        tick(2);
        pulse(5);
        chk("pin", 16'h0001, {15'h0, err_n});
        flags(16'h0000);
        host.wr(`SDIES_ADDR_ERROR_MASK, 16'h0000);
        host.rd(12'h0ff, d);
        chk("unmapped", 16'h0000, d);
    endtask
    task automatic t_clears();
        pulse(5);
        @(posedge i_sys_clk);
        fs <= 1'b1;
        @(posedge i_sys_clk);
        fs <= 1'b0;
        flags(16'h0000);
        @(posedge i_sys_clk);
        ev.luma_checksum <= 1'b1;
        fs <= 1'b1;
        @(posedge i_sys_clk);
        ev <= '0;
        fs <= 1'b0;
        flags(16'h0020);
        pulse(0);
        @(posedge i_sys_clk);
        sc <= 1'b1;
        @(posedge i_sys_clk);
        sc <= 1'b0;
        flags(16'h0000);
        pulse(5);
        @(posedge i_sys_clk);
        lk <= 1'b0;
        tick(8);
        chk("fmt", 16'h00ff, {8'h0, fo});
        flags(16'h0080);
        @(posedge i_sys_clk);
        lk <= 1'b1;
        tick(8);
        flags(16'h0080);
        flags(16'h0000);
        @(posedge i_sys_clk);
        md <= 5'h0b;
        pulse(5);
        @(posedge i_sys_clk);
        byp_n <= 1'b0;
        tick(8);
        flags(16'h0000);
        @(posedge i_sys_clk);
        byp_n <= 1'b1;
    endtask
    task automatic t_rerun();
        host.wr(`SDIES_ADDR_ERROR_MASK, 16'h0155);
        @(posedge i_sys_clk);
        i_reset <= 1'b1;
        tick(2);
        chk("fmt", 16'h00ff, {8'h0, fo});
        @(posedge i_sys_clk);
        i_reset <= 1'b0;
        host.rd(`SDIES_ADDR_ERROR_MASK, d);
        chk("mask", 16'h0000, d);
        tick(8);
        flags(16'h0080);
    endtask
    initial
    begin
        tick(8);
        chk("fmt", 16'h00ff, {8'h0, fo});
        i_reset <= 1'b0;
        t_reset();
        t_format();
        t_events();
        t_qualify();
        t_mask();
        t_clears();
        t_rerun();
        results();
    end
    initial
    begin
        #20000;
        fails++;
        results();
    end
endmodule
`default_nettype wire
